// [core/tbl_defs.vh]
// Purpose: constants for the transceiver self-test and loopback block
// Assumes: one code group per group tick, 9-bit code group {k, byte}
// Notes:   offsets are byte addresses on the register bus
`ifndef TBL_DEFS_VH
`define TBL_DEFS_VH

// register map
`define TBL_IDX_ERRCNT     5'd18
`define TBL_ADDR_CTRL      8'h00
`define TBL_ADDR_STAT      8'h04
`define TBL_ADDR_ERRCNT    8'h48
`define TBL_CTRL_CLR_BIT   0
`define TBL_RESP_OKAY      2'b00
`define TBL_RESP_SLVERR    2'b10

// test modes
`define TBL_MODE_NORMAL    3'd0
`define TBL_MODE_LOOP      3'd1
`define TBL_MODE_EXT_NOIDL 3'd2
`define TBL_MODE_EXT_IDL   3'd3
`define TBL_MODE_INT_IDL   3'd4
`define TBL_MODE_RSVD      3'd5

// code groups
`define TBL_K28_5          8'hBC
`define TBL_D21_5          8'hB5
`define TBL_D5_6           8'hC5
`define TBL_D16_2          8'h50
`define TBL_AN_CFG_LO      8'h00
`define TBL_AN_CFG_HI      8'h00

// sequence counts (in code groups)
`define TBL_PRE_IDLES      13'd4096
`define TBL_AN_GROUPS      13'd4096
`define TBL_INS_PERIOD     12'd2048
`define TBL_WORD_COMMAS    3'd4
`define TBL_LOCK_RUN       3'd4

// pseudo-noise seed and mismatch counter limits
`define TBL_PN_SEED        23'h7F_FFFF
`define TBL_CNT_MAX        8'hFF
`define TBL_MCNT_MAX       16'hFFFF

`endif

// [core/tbl_bist_top.v]
// Purpose: pin-selected loopback and built-in self test for two channels
// Assumes: test pins static while testing, system resets after a test
// Notes:   serial lines carry one 9-bit code group {k, byte} per group tick
// Contract
// - selectors low: normal when loopback enable low, internal loopback when high.
// - selector 0 only: self test over external loopback, idles only if chan A enable.
// - selector 1 only, enable low: internal-loopback self test with idles; rest reserved.
// - selectors low: per-channel enables; otherwise chan A enable rules all, B ignored.
// - loopback feeds channel's own transmitted groups back to its receiver.
// - in loopback serial inputs ignored; serial outputs follow output enable.
// - loopback with output enable low holds positive low, negative high.
// - transmitter makes pseudo-noise with polynomial 1 + x^5 + x^23.
// - receiver analyzer syncs to stream, compares each data group with reference.
// - mismatch count clears on self-test entry, updates throughout self test.
// - self test shows the 8-bit mismatch count on parallel receive data.
// - mismatch count saturates at all ones.
// - per-channel error counter in management register 18 in all self tests.
// - flags: not synced, running clean, comma group codes.
// - flags: synced not locked, mismatch group codes.
// - self test forces byte interface with codec and byte-aligned mode.
// - word sync in self test only in four-idle mode (select 1 low, 0 high).
// - on entry send 4096 idles, or auto-negotiation in ethernet mode, then pattern.
// - with idle insertion, one idle after every 2048 pattern groups.
// - ethernet mode inserts the /I1/I2/ ordered-set pair instead.
// - self test runs at reference clock rate and half-speed setting.
`timescale 1ns/100ps
`include "tbl_defs.vh"

module tbl_bist_top (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // test and configuration pins
  input  wire        test_select_lo,
  input  wire        test_select_hi,
  input  wire        chan_a_loopback_enable,
  input  wire        chan_b_loopback_enable,
  input  wire        loopback_output_enable,
  input  wire        ethernet_mode_a,
  input  wire        ten_bit_iface_enable,
  input  wire        byte_align_select,
  input  wire        word_align_select_1,
  input  wire        word_align_select_0,
  input  wire        half_speed_select,
  // transmit interface, channel b in [15:8], k flags per channel
  input  wire [15:0] tx_data,
  input  wire [1:0]  tx_k,
  // serial link, 9-bit code group per channel
  output reg  [17:0] serial_tx_pos,
  output reg  [17:0] serial_tx_neg,
  input  wire [17:0] serial_rx_pos,
  input  wire [17:0] serial_rx_neg,
  // receive interface
  output reg  [15:0] rx_parallel_data,
  output reg  [1:0]  rx_error_flag,
  output reg  [1:0]  rx_valid_flag,
  output reg  [1:0]  rx_sync_char_flag,
  // effective configuration
  output reg         ten_bit_iface_eff,
  output reg         byte_align_eff,
  output reg         bist_active,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam T_OFF = 2'd0;
  localparam T_PRE = 2'd1;
  localparam T_PN  = 2'd2;

  // eight steps of b[n] = b[n-5] ^ b[n-23], newest bit in bit 0
  function [22:0] pn_adv;
    input [22:0] h;
    integer i;
    begin
      pn_adv = h;
      for (i = 0; i < 8; i = i + 1) begin
        pn_adv = {pn_adv[21:0], pn_adv[4] ^ pn_adv[22]};
      end
    end
  endfunction

  // mode decode from the selector pins
  function [2:0] mode_of;
    input hi;
    input lo;
    input lbe;
    begin
      if (!hi && !lo) begin
        mode_of = lbe ? `TBL_MODE_LOOP : `TBL_MODE_NORMAL;
      end else if (!hi && lo) begin
        mode_of = lbe ? `TBL_MODE_EXT_IDL : `TBL_MODE_EXT_NOIDL;
      end else if (hi && !lo && !lbe) begin
        mode_of = `TBL_MODE_INT_IDL;
      end else begin
        mode_of = `TBL_MODE_RSVD;
      end
    end
  endfunction

  wire [2:0] mode      = mode_of(test_select_hi, test_select_lo, chan_a_loopback_enable);
  wire       in_bist   = (mode == `TBL_MODE_EXT_NOIDL) || (mode == `TBL_MODE_EXT_IDL) ||
                         (mode == `TBL_MODE_INT_IDL);
  wire       ins_idles = (mode == `TBL_MODE_EXT_IDL) || (mode == `TBL_MODE_INT_IDL);
  wire       word_mode = !word_align_select_1 && word_align_select_0;
  // per-channel loopback: own enable only when selectors low, else both on in internal self test, off otherwise
  wire [1:0] loop_en   = (mode == `TBL_MODE_INT_IDL) ? 2'b11 :
                         (!test_select_hi && !test_select_lo) ?
                         {chan_b_loopback_enable, chan_a_loopback_enable} : 2'b00;

  reg         bist_prev_r;
  reg         half_ph_r;
  wire        entry    = in_bist && !bist_prev_r;
  wire        grp_tick = !half_speed_select || half_ph_r;
  reg         clr_req_r;

  // shared self-test transmit sequencer
  reg  [1:0]  tx_st_r;
  reg  [12:0] pre_cnt_r;
  reg  [11:0] ins_cnt_r;
  reg  [1:0]  ins_ph_r;
  reg         ins_on_r;
  reg  [22:0] pn_r;
  reg  [8:0]  bist_grp_r;
  wire [22:0] pn_nxt   = pn_adv(pn_r);

  always @(posedge mclk) begin
    if (rst) begin
      bist_prev_r <= 1'b0;
      half_ph_r   <= 1'b0;
      tx_st_r     <= T_OFF;
      pre_cnt_r   <= 13'h0000;
      ins_cnt_r   <= 12'h000;
      ins_ph_r    <= 2'b00;
      ins_on_r    <= 1'b0;
      pn_r        <= `TBL_PN_SEED;
      bist_grp_r  <= {1'b1, `TBL_K28_5};
      ten_bit_iface_eff <= 1'b0;
      byte_align_eff    <= 1'b0;
      bist_active       <= 1'b0;
    end else begin
      bist_prev_r <= in_bist;
      half_ph_r   <= half_speed_select ? !half_ph_r : 1'b1;
      ten_bit_iface_eff <= ten_bit_iface_enable && !in_bist;
      byte_align_eff    <= byte_align_select || in_bist;
      bist_active       <= in_bist;
      if (!in_bist) begin
        tx_st_r <= T_OFF;
      end else if (entry) begin
        tx_st_r    <= T_PRE;
        // group 0 of the preamble is loaded here, so the count resumes at 1
        pre_cnt_r  <= 13'h0001;
        ins_cnt_r  <= 12'h000;
        ins_on_r   <= 1'b0;
        ins_ph_r   <= 2'b00;
        pn_r       <= `TBL_PN_SEED;
        bist_grp_r <= {1'b1, `TBL_K28_5};
      end else if (grp_tick) begin
        case (tx_st_r)
          T_PRE: begin
            if (ethernet_mode_a) begin
              // config ordered sets stand in for the negotiation exchange
              case (pre_cnt_r[1:0])
                2'd0: bist_grp_r <= {1'b1, `TBL_K28_5};
                2'd1: bist_grp_r <= {1'b0, `TBL_D21_5};
                2'd2: bist_grp_r <= {1'b0, `TBL_AN_CFG_LO};
                default: bist_grp_r <= {1'b0, `TBL_AN_CFG_HI};
              endcase
            end else begin
              bist_grp_r <= {1'b1, `TBL_K28_5};
            end
            pre_cnt_r <= pre_cnt_r + 13'h0001;
            if (pre_cnt_r == (ethernet_mode_a ? `TBL_AN_GROUPS : `TBL_PRE_IDLES) - 13'h0001) begin
              tx_st_r <= T_PN;
            end
          end
          T_PN: begin
            if (ins_on_r) begin
              if (ethernet_mode_a) begin
                case (ins_ph_r)
                  2'd0: bist_grp_r <= {1'b1, `TBL_K28_5};
                  2'd1: bist_grp_r <= {1'b0, `TBL_D5_6};
                  2'd2: bist_grp_r <= {1'b1, `TBL_K28_5};
                  default: bist_grp_r <= {1'b0, `TBL_D16_2};
                endcase
                ins_ph_r <= ins_ph_r + 2'b01;
                ins_on_r <= (ins_ph_r != 2'd3);
              end else begin
                bist_grp_r <= {1'b1, `TBL_K28_5};
                ins_on_r   <= 1'b0;
              end
            end else begin
              pn_r       <= pn_nxt;
              bist_grp_r <= {1'b0, pn_nxt[7:0]};
              if (ins_cnt_r == `TBL_INS_PERIOD - 12'h001) begin
                ins_cnt_r <= 12'h000;
                ins_on_r  <= ins_idles;
                ins_ph_r  <= 2'b00;
              end else begin
                ins_cnt_r <= ins_cnt_r + 12'h001;
              end
            end
          end
          default: tx_st_r <= T_OFF;
        endcase
      end
    end
  end

  wire [15:0] mcnt_w;
  wire [1:0]  sync_w;
  wire [1:0]  lock_w;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      // sequence groups go out from the cycle after entry, so no stale group leaks
      wire [8:0] tx_grp = bist_prev_r ? bist_grp_r : {tx_k[c], tx_data[8*c+7:8*c]};
      // loopback takes the channel's own group, never the serial input
      wire [8:0] rx_grp = loop_en[c] ? tx_grp : serial_rx_pos[9*c+8:9*c];
      wire       comma  = rx_grp[8] && (rx_grp[7:0] == `TBL_K28_5);
      reg  [2:0]  comma_run_r;
      reg         sync_r;
      reg         lock_r;
      reg         skip_r;
      reg  [2:0]  match_run_r;
      reg  [22:0] hist_r;
      reg  [22:0] ref_r;
      reg  [7:0]  cnt_r;
      reg  [15:0] mcnt_r;
      wire [22:0] ref_nxt  = pn_adv(ref_r);
      wire [22:0] hist_nxt = pn_adv(hist_r);
      wire        data_grp = !rx_grp[8] && !skip_r && sync_r;
      wire        mism     = lock_r && data_grp && (rx_grp[7:0] != ref_nxt[7:0]);
      assign mcnt_w[8*c+7:8*c] = (mcnt_r > 16'h00FF) ? 8'hFF : mcnt_r[7:0];
      assign sync_w[c] = sync_r;
      assign lock_w[c] = lock_r;

      always @(posedge mclk) begin
        if (rst) begin
          serial_tx_pos[9*c+8:9*c] <= 9'h000;
          serial_tx_neg[9*c+8:9*c] <= 9'h1FF;
          comma_run_r <= 3'b000;
          sync_r      <= 1'b0;
          lock_r      <= 1'b0;
          skip_r      <= 1'b0;
          match_run_r <= 3'b000;
          hist_r      <= `TBL_PN_SEED;
          ref_r       <= `TBL_PN_SEED;
          cnt_r       <= 8'h00;
          mcnt_r      <= 16'h0000;
          rx_parallel_data[8*c+7:8*c] <= 8'h00;
          rx_error_flag[c]     <= 1'b0;
          rx_valid_flag[c]     <= 1'b0;
          rx_sync_char_flag[c] <= 1'b0;
        end else begin
          if (loop_en[c] && !loopback_output_enable) begin
            serial_tx_pos[9*c+8:9*c] <= 9'h000;
            serial_tx_neg[9*c+8:9*c] <= 9'h1FF;
          end else begin
            serial_tx_pos[9*c+8:9*c] <= tx_grp;
            serial_tx_neg[9*c+8:9*c] <= ~tx_grp;
          end
          if (entry) begin
            mcnt_r <= 16'h0000;
          end else if (clr_req_r) begin
            // a mismatch in the clearing cycle is still counted
            mcnt_r <= {15'h0000, mism && grp_tick};
          end else if (mism && grp_tick && mcnt_r != `TBL_MCNT_MAX) begin
            mcnt_r <= mcnt_r + 16'h0001;
          end
          if (entry) begin
            comma_run_r <= 3'b000;
            sync_r      <= 1'b0;
            lock_r      <= 1'b0;
            skip_r      <= 1'b0;
            match_run_r <= 3'b000;
            hist_r      <= `TBL_PN_SEED;
            ref_r       <= `TBL_PN_SEED;
            cnt_r       <= 8'h00;
          end else if (in_bist && grp_tick) begin
            comma_run_r <= comma ? ((comma_run_r == 3'd7) ? 3'd7 : comma_run_r + 3'b001) : 3'b000;
            if (comma && (!word_mode || comma_run_r == `TBL_WORD_COMMAS - 3'b001)) begin
              sync_r <= 1'b1;
            end
            skip_r <= comma && ethernet_mode_a;
            if (data_grp) begin
              if (rx_grp[7:0] != 8'h00 || hist_r[14:0] != 15'h0000) begin
                hist_r <= {hist_r[14:0], rx_grp[7:0]};
              end
              if (lock_r) begin
                ref_r <= ref_nxt;
              end else if (hist_nxt[7:0] == rx_grp[7:0] && hist_r != 23'h00_0000) begin
                match_run_r <= match_run_r + 3'b001;
                if (match_run_r == `TBL_LOCK_RUN - 3'b001) begin
                  lock_r <= 1'b1;
                  ref_r  <= {hist_r[14:0], rx_grp[7:0]};
                end
              end else begin
                match_run_r <= 3'b000;
              end
            end
            if (mism && cnt_r != `TBL_CNT_MAX) begin
              cnt_r <= cnt_r + 8'h01;
            end
            if (mism && cnt_r != `TBL_CNT_MAX) begin
              rx_parallel_data[8*c+7:8*c] <= cnt_r + 8'h01;
            end else begin
              rx_parallel_data[8*c+7:8*c] <= cnt_r;
            end
            rx_error_flag[c]     <= (sync_r && !lock_r) || mism;
            rx_valid_flag[c]     <= lock_r;
            rx_sync_char_flag[c] <= lock_r && comma;
          end else if (!in_bist && grp_tick) begin
            rx_parallel_data[8*c+7:8*c] <= rx_grp[7:0];
            rx_error_flag[c]     <= 1'b0;
            rx_valid_flag[c]     <= !rx_grp[8];
            rx_sync_char_flag[c] <= comma;
          end
        end
      end
    end
  endgenerate

  // axi4-lite slave
  reg        aw_got_r;
  reg        w_got_r;
  reg  [7:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0] w_strb_r;

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TBL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TBL_RESP_OKAY;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      clr_req_r <= 1'b0;
    end else begin
      clr_req_r     <= 1'b0;
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == `TBL_ADDR_CTRL) begin
          s_axi_bresp <= `TBL_RESP_OKAY;
          clr_req_r   <= w_strb_r[0] && w_data_r[`TBL_CTRL_CLR_BIT];
        end else if (aw_addr_r == `TBL_ADDR_STAT || aw_addr_r == `TBL_ADDR_ERRCNT) begin
          s_axi_bresp <= `TBL_RESP_OKAY;
        end else begin
          s_axi_bresp <= `TBL_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `TBL_ADDR_CTRL) begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TBL_RESP_OKAY;
        end else if (s_axi_araddr == `TBL_ADDR_STAT) begin
          s_axi_rdata <= {24'h00_0000, lock_w, sync_w, in_bist, mode};
          s_axi_rresp <= `TBL_RESP_OKAY;
        end else if (s_axi_araddr == `TBL_ADDR_ERRCNT) begin
          s_axi_rdata <= {16'h0000, mcnt_w};
          s_axi_rresp <= `TBL_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TBL_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // tbl_bist_top

// [testbench/tbl_bist_asserts.sv]
// Purpose: concurrent checks on the self-test block ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound from the testbench top file
`timescale 1ns/100ps

module tbl_bist_asserts (
  // clock and reset
  input wire        mclk,
  input wire        rst,
  // test pins
  input wire        test_select_lo,
  input wire        test_select_hi,
  input wire        chan_a_loopback_enable,
  input wire        loopback_output_enable,
  // link and receive side
  input wire [17:0] serial_tx_pos,
  input wire [17:0] serial_tx_neg,
  input wire [15:0] rx_parallel_data,
  // effective configuration
  input wire        ten_bit_iface_eff,
  input wire        byte_align_eff,
  input wire        bist_active,
  // bus responses
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire sel_bist  = (test_select_lo & ~test_select_hi)
                 | (test_select_hi & ~test_select_lo & ~chan_a_loopback_enable);
  wire sel_norm  = ~test_select_lo & ~test_select_hi;
  wire quiet_a   = sel_norm & chan_a_loopback_enable & ~loopback_output_enable;

  sequence s_pins_bist;
    sel_bist [*4];
  endsequence
  sequence s_bist_run;
    bist_active [*8];
  endsequence

  a_neg_complement: assert property (serial_tx_neg == ~serial_tx_pos)
    else $error("negative line not inverse of positive");
  a_loop_quiet: assert property (quiet_a [*4] |-> serial_tx_pos[8:0] == 9'h000)
    else $error("quiet loopback link not held");
  a_bist_enter: assert property (s_pins_bist |-> bist_active)
    else $error("self test not active");
  a_normal_mode: assert property (sel_norm [*4] |-> !bist_active)
    else $error("self test active in normal mode");
  a_bist_config: assert property (bist_active [*2] |-> !ten_bit_iface_eff && byte_align_eff)
    else $error("self test config not forced");
  a_count_clear: assert property ($rose(bist_active) |-> ##[0:8] rx_parallel_data == 16'h0000)
    else $error("count not cleared on entry");
  a_count_sticky: assert property (s_bist_run |-> rx_parallel_data[7:0] >= $past(rx_parallel_data[7:0]))
    else $error("count decreased or wrapped");
  a_write_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule // tbl_bist_asserts

// [testbench/tbl_link_echo.sv]
// Purpose: far end of the serial link, an external loopback cable
// Assumes: one code group per clock on each lane
// Notes:   corrupt flips the low data bit of both lanes
`timescale 1ns/100ps

module tbl_link_echo (
  // clock
  input  wire        mclk,
  // bench control
  input  wire        corrupt,
  // link
  input  wire [17:0] tx_pos,
  output reg  [17:0] rx_pos,
  output wire [17:0] rx_neg
);
  // one cable stage of delay
  always @(posedge mclk) begin
    rx_pos <= corrupt ? (tx_pos ^ 18'h0_0201) : tx_pos;
  end
  assign rx_neg = ~rx_pos;
endmodule // tbl_link_echo

// [testbench/tb_transceiver_bist_loopback_test.sv]
// Purpose: directed bench for loopback and self-test modes
// Assumes: selector pins change only around a reset
// Notes:   external modes loop through the link echo model
`timescale 1ns/100ps
`include "tbl_defs.vh"

module tb_transceiver_bist_loopback_test;
  logic        mclk, rst, test_select_lo, test_select_hi, chan_a_loopback_enable;
  logic        chan_b_loopback_enable, loopback_output_enable, ethernet_mode_a;
  logic        ten_bit_iface_enable, byte_align_select, half_speed_select;
  logic        word_align_select_1, word_align_select_0, corrupt;
  logic [15:0] tx_data, rx_parallel_data;
  logic [1:0]  tx_k, rx_error_flag, rx_valid_flag, rx_sync_char_flag, s_axi_bresp, s_axi_rresp;
  logic [17:0] serial_tx_pos, serial_tx_neg, serial_rx_pos, serial_rx_neg;
  logic        ten_bit_iface_eff, byte_align_eff, bist_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fail_count, n_tests;

  tbl_bist_top dut (.mclk, .rst, .test_select_lo, .test_select_hi, .chan_a_loopback_enable,
    .chan_b_loopback_enable, .loopback_output_enable, .ethernet_mode_a, .ten_bit_iface_enable,
    .byte_align_select, .word_align_select_1, .word_align_select_0, .half_speed_select,
    .tx_data, .tx_k, .serial_tx_pos, .serial_tx_neg, .serial_rx_pos, .serial_rx_neg,
    .rx_parallel_data, .rx_error_flag, .rx_valid_flag, .rx_sync_char_flag, .ten_bit_iface_eff,
    .byte_align_eff, .bist_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  tbl_link_echo echo (.mclk, .corrupt, .tx_pos(serial_tx_pos), .rx_pos(serial_rx_pos),
    .rx_neg(serial_rx_neg));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    chk("rdata", s_axi_rdata, exp);
    @(posedge mclk);
  endtask

  // pins are set while reset is held, first sample one edge after release
  task automatic run_bist(input logic hi, input logic lo, input logic a, input int exp_k,
                          input logic [2:0] md);
    int n;
    test_select_hi         <= hi;
    test_select_lo         <= lo;
    chan_a_loopback_enable <= a;
    rst                    <= 1'b1;
    tick(2);
    rst <= 1'b0;
    @(posedge mclk);
    n = 0;
    while (serial_tx_pos[8] !== 1'b1) @(posedge mclk);
    while (serial_tx_pos[8] === 1'b1) begin
      n++;
      @(posedge mclk);
    end
    chk("preamble", n, 4096);
    n = 0;
    repeat (4100) begin
      @(posedge mclk);
      if (serial_tx_pos[8] === 1'b1) n++;
    end
    chk("idles", n, exp_k);
    chk("flags", {rx_error_flag, rx_valid_flag, rx_sync_char_flag}, 6'b001100);
    chk("count", rx_parallel_data, 16'h0000);
    chk("cfg", {ten_bit_iface_eff, byte_align_eff, bist_active}, 3'b011);
    axi_rd(`TBL_ADDR_STAT, {24'h00_0000, 4'hF, 1'b1, md}, `TBL_RESP_OKAY);
    axi_rd(`TBL_ADDR_ERRCNT, 32'h0000_0000, `TBL_RESP_OKAY);
    $display("test self test mode %0d done", md);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    tick(60000);
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    {rst, test_select_lo, test_select_hi, chan_a_loopback_enable} = 4'h8;
    {chan_b_loopback_enable, loopback_output_enable, ethernet_mode_a} = 3'h0;
    {ten_bit_iface_enable, byte_align_select, half_speed_select, corrupt} = 4'h4;
    {word_align_select_1, word_align_select_0, tx_k, tx_data} = 20'h0_0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hF;
    fail_count  = 0;
    n_tests     = 0;
    tick(2);
    chk("reset pos", serial_tx_pos, 18'h0_0000);
    chk("reset neg", serial_tx_neg, 18'h3_FFFF);
    chk("reset rx", rx_parallel_data, 16'h0000);
    tx_data <= 16'hA55A;
    corrupt <= 1'b1;
    rst     <= 1'b0;
    tick(8);
    chk("normal rx", rx_parallel_data, 16'hA45B);
    chk("normal valid", rx_valid_flag, 2'b11);
    chk("normal cfg", {ten_bit_iface_eff, byte_align_eff, bist_active}, 3'b010);
    chan_a_loopback_enable <= 1'b1;
    tick(8);
    chk("loop rx", rx_parallel_data, 16'hA45A);
    chk("loop quiet", serial_tx_pos[8:0], 9'h000);
    loopback_output_enable <= 1'b1;
    tick(4);
    chk("loop drive", serial_tx_pos, 18'h1_4A5A);
    tx_k    <= 2'b11;
    tx_data <= 16'hBCBC;
    tick(4);
    chk("comma flags", {rx_sync_char_flag, rx_valid_flag}, 4'b0100);
    tx_k    <= 2'b00;
    $display("test normal and loopback done");
    // reserved selector codes are never applied
    ten_bit_iface_enable   <= 1'b1;
    byte_align_select      <= 1'b0;
    word_align_select_0    <= 1'b1;
    chan_b_loopback_enable <= 1'b1;
    run_bist(1'b1, 1'b0, 1'b0, 2, `TBL_MODE_INT_IDL);
    corrupt <= 1'b0;
    run_bist(1'b0, 1'b1, 1'b1, 2, `TBL_MODE_EXT_IDL);
    run_bist(1'b0, 1'b1, 1'b0, 0, `TBL_MODE_EXT_NOIDL);
    corrupt <= 1'b1;
    tick(400);
    chk("mismatch flags", {rx_error_flag, rx_valid_flag}, 4'b1111);
    chk("saturated", rx_parallel_data, 16'hFFFF);
    axi_rd(`TBL_ADDR_ERRCNT, 32'h0000_FFFF, `TBL_RESP_OKAY);
    corrupt <= 1'b0;
    tick(50);
    axi_wr(`TBL_ADDR_CTRL, 32'h0000_0001, `TBL_RESP_OKAY);
    axi_rd(`TBL_ADDR_ERRCNT, 32'h0000_0000, `TBL_RESP_OKAY);
    chk("pin count kept", rx_parallel_data, 16'hFFFF);
    axi_rd(8'h10, 32'h0000_0000, `TBL_RESP_SLVERR);
    axi_wr(8'h20, 32'h0000_0000, `TBL_RESP_SLVERR);
    $display("test mismatch counting done");
    report_and_stop();
  end
endmodule // tb_transceiver_bist_loopback_test

bind tbl_bist_top tbl_bist_asserts u_chk (.mclk, .rst, .test_select_lo, .test_select_hi,
  .chan_a_loopback_enable, .loopback_output_enable, .serial_tx_pos, .serial_tx_neg,
  .rx_parallel_data, .ten_bit_iface_eff, .byte_align_eff, .bist_active, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready);
